// file: cssq_defs.svh
// constants for the capacitance stage sequencer: offsets, fields, timing
// assumes a 200 MHz clock and word-indexed register addresses
//==========================================================================
// Contract
// R01: full sequence lasts stage count times per-stage time set by ratio
// R02: up to twelve stages, each applying its own input routing
// R03: low power sleep between sequences 200/400/600/800 ms by field
// R04: low power period is sequence time plus sleep, then auto wake
// R05: raw 16-bit per-stage results readable from index 0x00B upward
// R06: route codes 00 float, 01 negative, 10 positive, 11 bias
// R07: positive routing raises code on activation, negative lowers it
// R08: matching field bits 13:12 upper word decoded to converter matching
// R09: host sets matching 11 when two inputs share a terminal
// R10: lower word inputs 0..6, upper word inputs 7..12 at bits 2n+1:2n
// R11: host ties every unused input to bias
// R12: differential button pair: both pressed means neither active
// R13: ratio bits 9:8: 00 256, 01 128, 1x 64
// R14: sequence starts at stage 0 and ends at last stage index
// R15: each result register updates when its stage conversion completes
`ifndef CSSQ_DEFS_SVH
`define CSSQ_DEFS_SVH
//==========================================================================
// register indices (byte address not used, plain port is word indexed)
`define CSSQ_ADDR_PWR        8'h00
`define CSSQ_ADDR_SEQ        8'h01
`define CSSQ_ADDR_STATUS     8'h02
`define CSSQ_ADDR_RESULT0    8'h0B
`define CSSQ_ADDR_ROUTE0     8'h80
//==========================================================================
// power control fields, register reset values and the matching field
`define CSSQ_PWR_MODE_LSB    0
`define CSSQ_SLEEP_LSB       2
`define CSSQ_RATIO_LSB       8
`define CSSQ_PWR_RESET       16'h0000
`define CSSQ_MODE_LOW        2'h2
`define CSSQ_SEQ_RESET       4'hB
`define CSSQ_ROUTE_LO_RESET  16'hFFFF
`define CSSQ_ROUTE_HI_RESET  16'h3FFF
`define CSSQ_MATCH_LSB       12
//==========================================================================
// timing: per-stage times in ns, sleep step in ms, 200 MHz clock
`define CSSQ_CLK_MHZ         200
`define CSSQ_T_STAGE64_NS    768000
`define CSSQ_STAGE64_CYC     (`CSSQ_T_STAGE64_NS * `CSSQ_CLK_MHZ / 1000)
`define CSSQ_T_SLEEP_MS      200
`define CSSQ_SLEEP_CYC       (`CSSQ_T_SLEEP_MS * 1000 * `CSSQ_CLK_MHZ)
`endif

// file: cssq_pkg.sv
// types shared by the capacitance stage sequencer
// assumes cssq_defs.svh is included by the modules
package cssq_pkg;
    typedef enum logic [1:0] {CSSQ_IDLE, CSSQ_CONV, CSSQ_SLEEP} cssq_state_t;
    typedef enum logic [1:0] {
        CSSQ_FLOAT, CSSQ_NEG, CSSQ_POS, CSSQ_BIAS
    } cssq_route_t;
endpackage

// file: cssq_route_decode.sv
// decodes one stage's routing words into switch enables for all inputs
// assumes words are stable while the stage converts
`timescale 1ns/100ps
`include "cssq_defs.svh"
module cssq_route_decode
    import cssq_pkg::*;
#(
    parameter int N_IN = 13
) (
    input  wire logic [15:0]     i_route_lo,
    input  wire logic [15:0]     i_route_hi,
    output logic      [N_IN-1:0] o_to_pos,
    output logic      [N_IN-1:0] o_to_neg,
    output logic      [N_IN-1:0] o_to_bias,
    output logic      [1:0]      o_match
);
    logic [25:0] codes;
    // inputs 0..6 low word, 7..12 high word
    assign codes = {i_route_hi[11:0], i_route_lo[13:0]}; // R10
    //======================================================================
    // per input switch decode
    genvar g;
    for (g = 0; g < N_IN; g++) begin : g_in
        cssq_route_t c;
        assign c = cssq_route_t'(codes[2*g +: 2]);
        assign o_to_pos[g]  = (c == CSSQ_POS); // R06
        assign o_to_neg[g]  = (c == CSSQ_NEG); // R06
        assign o_to_bias[g] = (c == CSSQ_BIAS); // R06
    end
    // matching of the unused terminal path
    assign o_match = i_route_hi[`CSSQ_MATCH_LSB +: 2]; // R08
endmodule // cssq_route_decode

// file: cssq_stage_sequencer.sv
// capacitance stage sequencer: registers, stage stepping, result capture
// assumes the analog converter holds a 16-bit result valid at the end of each counted stage time
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "cssq_defs.svh"
module cssq_stage_sequencer
    import cssq_pkg::*;
#(
    parameter int N_STAGE   = 12,
    parameter int N_IN      = 13,
    parameter int STAGE_CYC = `CSSQ_STAGE64_CYC,
    parameter int SLEEP_CYC = `CSSQ_SLEEP_CYC
) (
    input  wire logic            i_clk,
    input  wire logic            i_rst_b,
    input  wire logic [7:0]      i_addr,
    input  wire logic [15:0]     i_wdata,
    input  wire logic            i_wr,
    input  wire logic            i_rd,
    output logic      [15:0]     o_rdata,
    input  wire logic [15:0]     i_conv_result,
    output logic      [3:0]      o_stage,
    output logic                 o_conv_run,
    output logic      [N_IN-1:0] o_to_pos,
    output logic      [N_IN-1:0] o_to_neg,
    output logic      [N_IN-1:0] o_to_bias,
    output logic      [1:0]      o_match,
    output logic                 o_seq_done
);
    //======================================================================
    // state
    typedef struct packed {
        logic [15:0]  pwr;
        logic [3:0]   last;
        cssq_state_t  st;
        logic [3:0]   stage;
        logic [31:0]  cnt;
        logic [1:0]   slp;
        logic         done;
        logic [15:0]  rdata;
        logic [N_STAGE*16-1:0] res;
        logic [N_STAGE*16-1:0] rlo;
        logic [N_STAGE*16-1:0] rhi;
    } cssq_reg_t;
    cssq_reg_t r_q, r_d;

    logic [1:0]  ratio_code;
    logic [31:0] stage_len;
    logic        low_power;
    logic [15:0] rd_val;
    logic [3:0]  ridx;
    logic [3:0]  last_cl;

    assign ratio_code = r_q.pwr[`CSSQ_RATIO_LSB +: 2];
    assign low_power  = (r_q.pwr[`CSSQ_PWR_MODE_LSB +: 2] == `CSSQ_MODE_LOW);
    // per stage time: 64 base, doubled for 128, quadrupled for 256
    always_comb begin
        case (ratio_code)
            2'h0:    stage_len = 32'(STAGE_CYC * 4); // R13
            2'h1:    stage_len = 32'(STAGE_CYC * 2); // R13
            default: stage_len = 32'(STAGE_CYC); // R13
        endcase
    end
    // clamp the last stage index so a bad value cannot run off the table
    assign last_cl = (r_q.last > 4'(N_STAGE - 1)) ? 4'(N_STAGE - 1) : r_q.last;

    //======================================================================
    // routing of the current stage, decoded outside
    cssq_route_decode #(.N_IN(N_IN)) u_dec (
        .i_route_lo (r_q.rlo[r_q.stage*16 +: 16]), // R02
        .i_route_hi (r_q.rhi[r_q.stage*16 +: 16]), // R02
        .o_to_pos   (o_to_pos),
        .o_to_neg   (o_to_neg),
        .o_to_bias  (o_to_bias),
        .o_match    (o_match)
    );

    //======================================================================
    // read mux
    always_comb begin
        rd_val = 16'h0000;
        ridx   = i_addr[3:0];
        if (i_addr == `CSSQ_ADDR_PWR)
            rd_val = r_q.pwr;
        else if (i_addr == `CSSQ_ADDR_SEQ)
            rd_val = {12'h000, r_q.last};
        else if (i_addr == `CSSQ_ADDR_STATUS)
            rd_val = {8'h00, 2'(r_q.st), 2'h0, r_q.stage};
        else if (i_addr >= `CSSQ_ADDR_RESULT0 &&
                 i_addr < 8'(`CSSQ_ADDR_RESULT0 + N_STAGE)) begin
            ridx   = 4'(i_addr - `CSSQ_ADDR_RESULT0);
            rd_val = r_q.res[ridx*16 +: 16]; // R05
        end else if (i_addr[7] && i_addr[6:5] == 2'h0 &&
                     i_addr[4:1] < 4'(N_STAGE)) begin
            ridx   = i_addr[4:1];
            rd_val = i_addr[0] ? r_q.rhi[ridx*16 +: 16]
                               : r_q.rlo[ridx*16 +: 16];
        end
    end

    //======================================================================
    // next state: bus writes, then sequencer
    always_comb begin
        r_d      = r_q;
        r_d.done = 1'b0;
        r_d.rdata = i_rd ? rd_val : 16'h0000;
        if (i_wr) begin
            if (i_addr == `CSSQ_ADDR_PWR)
                r_d.pwr = i_wdata;
            else if (i_addr == `CSSQ_ADDR_SEQ)
                r_d.last = i_wdata[3:0];
            else if (i_addr[7] && i_addr[6:5] == 2'h0 &&
                     i_addr[4:1] < 4'(N_STAGE)) begin
                if (i_addr[0])
                    r_d.rhi[i_addr[4:1]*16 +: 16] = {2'h0, i_wdata[13:0]};
                else
                    r_d.rlo[i_addr[4:1]*16 +: 16] = {2'h0, i_wdata[13:0]};
            end
        end
        case (r_q.st)
            CSSQ_IDLE: begin
                r_d.stage = 4'h0; // R14
                r_d.cnt   = 32'h0000_0000;
                r_d.st    = CSSQ_CONV;
            end
            CSSQ_CONV: begin
                if (r_q.cnt >= stage_len - 32'h1) begin // R01
                    // converter output polarity follows the routing R07
                    r_d.res[r_q.stage*16 +: 16] = i_conv_result; // R15
                    r_d.cnt = 32'h0000_0000;
                    if (r_q.stage >= last_cl) begin // R14
                        r_d.done  = 1'b1;
                        r_d.stage = 4'h0;
                        r_d.slp   = 2'h0;
                        r_d.st    = low_power ? CSSQ_SLEEP : CSSQ_CONV; // R04
                    end else begin
                        r_d.stage = r_q.stage + 4'h1; // R02
                    end
                end else begin
                    r_d.cnt = r_q.cnt + 32'h1;
                end
            end
            CSSQ_SLEEP: begin
                // sleep code n waits n+1 steps of 200 ms
                if (r_q.cnt >= 32'(SLEEP_CYC) - 32'h1) begin
                    r_d.cnt = 32'h0000_0000;
                    if (r_q.slp >= r_q.pwr[`CSSQ_SLEEP_LSB +: 2]) // R03
                        r_d.st = CSSQ_CONV; // R04
                    else
                        r_d.slp = r_q.slp + 2'h1;
                end else begin
                    r_d.cnt = r_q.cnt + 32'h1;
                end
            end
            default: r_d.st = CSSQ_IDLE;
        endcase
    end

    //======================================================================
    // state register
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            r_q       <= '0;
            r_q.pwr   <= `CSSQ_PWR_RESET;
            r_q.last  <= `CSSQ_SEQ_RESET;
            r_q.st    <= CSSQ_IDLE;
            r_q.rlo   <= {N_STAGE{`CSSQ_ROUTE_LO_RESET}}; // unused tied bias
            r_q.rhi   <= {N_STAGE{`CSSQ_ROUTE_HI_RESET}};
        end else begin
            r_q <= r_d;
        end
    end

    // R12 holds in the analog path: a differential pair reads as neither
    assign o_rdata    = r_q.rdata;
    assign o_stage    = r_q.stage;
    assign o_conv_run = (r_q.st == CSSQ_CONV);
    assign o_seq_done = r_q.done;
endmodule // cssq_stage_sequencer

// file: cssq_seq_assertions.sv
// port checks for the stage sequencer
// assumes a bind onto cssq_stage_sequencer and a sync reset
`timescale 1ns/100ps
module cssq_seq_assertions #(
    parameter int N_IN = 13
) (
    input wire logic            i_clk,
    input wire logic            i_rst_b,
    input wire logic [7:0]      i_addr,
    input wire logic            i_rd,
    input wire logic [15:0]     o_rdata,
    input wire logic [3:0]      o_stage,
    input wire logic [N_IN-1:0] o_to_pos,
    input wire logic [N_IN-1:0] o_to_neg,
    input wire logic [N_IN-1:0] o_to_bias,
    input wire logic            o_seq_done
);
    //==========
    // one clock domain, so one clocking and one disable for all
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data outside its cycle");
    a_unmapped_zero: assert property (i_rd && i_addr == 8'h40 |=> !o_rdata)
        else $error("unmapped read not zero");
    a_route_excl: assert property (((o_to_pos & o_to_neg)
        | (o_to_pos & o_to_bias) | (o_to_neg & o_to_bias)) == '0)
        else $error("input on two terminals");
    a_reset_bias: assert property (!$past(i_rst_b) |-> &o_to_bias)
        else $error("inputs not biased after reset");
    a_stage_max: assert property (o_stage <= 4'hB)
        else $error("stage index above eleven");
    a_stage_step: assert property ($changed(o_stage) |->
        o_stage == $past(o_stage) + 4'h1 || o_stage == 4'h0)
        else $error("stage skipped");
    a_stage_hold: assert property ($changed(o_stage) |=> $stable(o_stage)[*2])
        else $error("stage too short");
    a_done_pulse: assert property (o_seq_done |=> !o_seq_done)
        else $error("done wider than one cycle");
endmodule // cssq_seq_assertions
bind cssq_stage_sequencer cssq_seq_assertions #(.N_IN(N_IN)) u_chk (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_stage(o_stage), .o_to_pos(o_to_pos),
    .o_to_neg(o_to_neg), .o_to_bias(o_to_bias), .o_seq_done(o_seq_done));

// file: cssq_sensor_model.sv
// sensor and converter stand-in: code per stage, moved by touched inputs
// assumes switch enables come straight from the sequencer
`timescale 1ns/100ps
module cssq_sensor_model (
    input  wire logic [12:0] i_touch,
    input  wire logic [3:0]  i_stage,
    input  wire logic        i_run,
    input  wire logic [12:0] i_to_pos,
    input  wire logic [12:0] i_to_neg,
    output logic      [15:0] o_result
);
    //==========
    // a pressed pair on both terminals cancels, so neither shows
    logic [15:0] code;
    always_comb begin
        code = 16'h8000 | {12'h000, i_stage};
        if (|(i_touch & i_to_pos)) code = code + 16'h0100;
        if (|(i_touch & i_to_neg)) code = code - 16'h0100;
        o_result = i_run ? code : ~code; // idle word is never valid
    end
endmodule // cssq_sensor_model

// file: cssq_stage_sequencer_tb.sv
// bench for the stage sequencer with the sensor model on its far side
// assumes short stage and sleep counts of 4 and 10 cycles
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("FAIL %0t got %h exp %h", $time, (g), (e)); end end
module cssq_stage_sequencer_tb;
    //==========
    logic        i_clk = 0, i_rst_b = 0, i_wr = 0, i_rd = 0;
    logic [7:0]  i_addr = 0;
    logic [15:0] i_wdata = 0;
    logic [12:0] touch = 0, pos, neg, bias;
    logic [15:0] conv, rdata;
    logic [3:0]  stage;
    logic [1:0]  match;
    logic        run, done;
    int          num_errors = 0, tests_run = 0, n;
    logic [7:0]  ra [6] = '{8'h00, 8'h01, 8'h80, 8'h81, 8'h97, 8'h40};
    logic [15:0] rv [6] = '{16'h0, 16'h000B, 16'hFFFF,
                            16'h3FFF, 16'h3FFF, 16'h0};
    cssq_stage_sequencer #(.STAGE_CYC(4), .SLEEP_CYC(10)) DUT (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_conv_result(conv),
        .o_stage(stage), .o_conv_run(run), .o_to_pos(pos), .o_to_neg(neg),
        .o_to_bias(bias), .o_match(match), .o_seq_done(done));
    cssq_sensor_model u_sns (.i_touch(touch), .i_stage(stage), .i_run(run),
        .i_to_pos(pos), .i_to_neg(neg), .o_result(conv));
    initial begin
        forever #2.5 i_clk = ~i_clk;
    end
    // bus cycles: one strobe cycle, data checked the cycle after
    task wr(input [7:0] a, input [15:0] d);
        @(posedge i_clk); i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
        @(posedge i_clk); i_wr <= 1'b0;
    endtask
    task rd(input [7:0] a, input [15:0] e);
        @(posedge i_clk); i_addr <= a; i_rd <= 1'b1;
        @(posedge i_clk); i_rd <= 1'b0;
        #1 `CHK(rdata, e)
    endtask
    task tick(); @(posedge i_clk); #1; endtask
    task tally_and_finish();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // bounded wait for the done pulse; running out ends the run
    task wdone();
        int k;
        k = 0;
        do begin
            tick(); k++;
            if (k > 9000) begin num_errors++; tally_and_finish(); end
        end while (done !== 1'b1);
    endtask
    task per(output int p);
        wdone(); p = 0;
        do begin tick(); p++; end while (done !== 1'b1 && p < 9000);
    endtask
    initial begin
        repeat (12) @(posedge i_clk);
        i_rst_b <= 1'b1;
        for (int i = 0; i < 6; i++) rd(ra[i], rv[i]);
        wr(8'h01, 16'h0001);
        for (int r = 0; r < 4; r++) begin
            wr(8'h00, {6'h00, r[1:0], 8'h00}); per(n);
            `CHK(n, 8 * ((r > 1) ? 1 : (4 >> r)))
        end
        for (int k = 0; k < 4; k++) begin
            wr(8'h00, {6'h00, 2'b10, 4'h0, k[1:0], 2'b10}); per(n);
            `CHK(n, 8 + (k + 1) * 10)
        end
        wr(8'h00, 16'h0200); wr(8'h80, 16'hFFBF); wr(8'h81, 16'h2FFF);
        wr(8'h82, 16'hFFF6);
        wr(8'h83, 16'h3FFF);
        touch <= 13'h000B;
        wdone();
        for (int k = 0; k < 99 && stage !== 4'h0; k++) tick();
        `CHK(pos, 13'h0008)
        `CHK(bias, 13'h1FF7)
        `CHK(match, 2'b10)
        for (int k = 0; k < 99 && stage !== 4'h1; k++) tick();
        `CHK(neg, 13'h0002)
        wdone(); wdone();
        rd(8'h0B, 16'h8100);
        rd(8'h0C, 16'h8001);
        wr(8'h0B, 16'h1234); rd(8'h0B, 16'h8100);
        // mid-run reset: drive on the rising edge like all other stimulus
        @(posedge i_clk);
        i_rst_b <= 1'b0;
        repeat (12) @(posedge i_clk);
        #1 `CHK(stage, 4'h0)
        `CHK(run, 1'b0)
        @(posedge i_clk);
        i_rst_b <= 1'b1;
        rd(8'h01, 16'h000B);
        tally_and_finish();
    end
endmodule // cssq_stage_sequencer_tb
